/* File: design/grouped_interrupt_expander.sv */
// interrupt expander: source latching, group requests, vector decode and register port
`timescale 1ns/1ps
module grouped_interrupt_expander
	import expander_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic [SOURCES-1:0]   src_req,
	input  wire logic                 protected_write_enable,
	input  wire logic [ADDR_W-1:0]    reg_addr,
	input  wire logic [DATA_W-1:0]    reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [DATA_W-1:0]    reg_rdata,
	output logic      [GROUPS-1:0]    cpu_line_req,
	input  wire logic                 vec_req,
	input  wire logic [LINE_W-1:0]    vec_line,
	input  wire logic                 vec_sw,
	output logic                      vec_valid,
	output logic                      vec_mapped,
	output logic      [2*TABLE_WIDTH-1:0] vec_data
);
	// index of a multiplexed vector inside the store
	function automatic logic [7:0] mux_index(input logic [3:0] grp, input logic [2:0] pos);
		return 8'(MUX_TABLE_BASE + 8'(8'(grp) * GROUP_STRIDE) + 8'(8'(pos) * ENTRY_WORDS));
	endfunction

	// lowest set bit wins, bit 0 is position one
	function automatic logic [2:0] first_set(input logic [7:0] v);
		logic [2:0] r;
		r = 3'h0;
		for (int i = SRC_PER_GROUP - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	table_if tbl ();

	vector_store u_store (
		.clk  (clk),
		.port (tbl.store)
	);

	logic [SOURCES-1:0]       sync1;
	logic [SOURCES-1:0]       sync2;
	logic [SOURCES-1:0]       sync3;
	logic [SOURCES-1:0]       src_level;
	logic [SOURCES-1:0]       next_level;
	logic [SOURCES-1:0]       src_rise;
	logic [7:0]               group_pending_flags [GROUPS];
	logic [7:0]               group_source_enables [GROUPS];
	logic [GROUPS-1:0]        group_ack_latch;
	logic [GROUPS-1:0]        group_fire;
	logic [SOURCES-1:0]       pend_flat;
	logic                     expander_enable;
	logic [3:0]               fetch_grp;
	logic                     fetch_is_mux;
	logic [7:0]               fetch_hits;
	logic [2:0]               fetch_pos;
	logic                     fetch_clear;
	logic [7:0]               fetch_index;
	logic [DATA_W-1:0]        next_rdata;

	// three-stage synchroniser; a change counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1     <= '0;
			sync2     <= '0;
			sync3     <= '0;
			src_level <= '0;
		end else begin
			sync1     <= src_req;
			sync2     <= sync1;
			sync3     <= sync2;
			src_level <= next_level;
		end
	end

	// a request is taken on its rising edge; the peripheral gates it itself
	assign next_level = ((sync2 ~^ sync3) & sync2) | ((sync2 ^ sync3) & src_level);
	assign src_rise   = next_level & ~src_level;

	// vector fetch decode for the requested line
	always_comb begin
		fetch_grp    = 4'(vec_line - FIRST_MUX_LINE);
		fetch_is_mux = expander_enable && (vec_line >= FIRST_MUX_LINE) && (vec_line <= LAST_MUX_LINE);
		fetch_hits   = fetch_is_mux ? (group_pending_flags[fetch_grp] & group_source_enables[fetch_grp]) : 8'h00;
		fetch_pos    = (!vec_sw && (fetch_hits != 8'h00)) ? first_set(fetch_hits) : 3'h0;
		fetch_clear  = vec_req && fetch_is_mux && !vec_sw && (fetch_hits != 8'h00);
		if (fetch_is_mux) begin
			fetch_index = mux_index(fetch_grp, fetch_pos);
		end else begin
			fetch_index = 8'(8'(vec_line) * ENTRY_WORDS);
		end
	end

	// pending flags: a new request or software set wins over the fetch clear
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int g = 0; g < GROUPS; g++) begin
				group_pending_flags[g] <= 8'h00;
			end
		end else begin
			for (int g = 0; g < GROUPS; g++) begin
				for (int s = 0; s < SRC_PER_GROUP; s++) begin
					if (src_rise[g*SRC_PER_GROUP+s]) begin
						group_pending_flags[g][s] <= 1'b1;
					end else if (reg_wr && reg_addr == 9'(ADDR_PEND_BASE + 9'(g)) && reg_wdata[s]) begin
						group_pending_flags[g][s] <= 1'b1;
					end else if (fetch_clear && fetch_grp == 4'(g) && fetch_pos == 3'(s)) begin
						group_pending_flags[g][s] <= 1'b0;
					end
				end
			end
		end
	end

	// per-source enables, written whole by software
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int g = 0; g < GROUPS; g++) begin
				group_source_enables[g] <= 8'h00;
			end
		end else begin
			for (int g = 0; g < GROUPS; g++) begin
				if (reg_wr && reg_addr == 9'(ADDR_EN_BASE + 9'(g))) begin
					group_source_enables[g] <= reg_wdata[7:0];
				end
			end
		end
	end

	// a group fires when an enabled source is pending and its acknowledge is clear
	always_comb begin
		for (int g = 0; g < GROUPS; g++) begin
			group_fire[g] = ((group_pending_flags[g] & group_source_enables[g]) != 8'h00) && !group_ack_latch[g];
			pend_flat[g*SRC_PER_GROUP +: SRC_PER_GROUP] = group_pending_flags[g];
		end
	end

	// every group drives its own line; the cpu orders lines itself
	always_ff @(posedge clk) begin
		if (rst) begin
			cpu_line_req <= '0;
		end else begin
			cpu_line_req <= group_fire;
		end
	end

	// acknowledge latch: set on firing, cleared by writing ones; the set wins
	always_ff @(posedge clk) begin
		if (rst) begin
			group_ack_latch <= '0;
		end else begin
			for (int g = 0; g < GROUPS; g++) begin
				if (group_fire[g]) begin
					group_ack_latch[g] <= 1'b1;
				end else if (reg_wr && reg_addr == ADDR_ACK && reg_wdata[g]) begin
					group_ack_latch[g] <= 1'b0;
				end
			end
		end
	end

	// expander enable
	always_ff @(posedge clk) begin
		if (rst) begin
			expander_enable <= ENABLE_RESET;
		end else if (reg_wr && reg_addr == ADDR_CTRL) begin
			expander_enable <= reg_wdata[CTRL_ENABLE_BIT];
		end
	end

	// vector store hookup; writes need protected write enable
	assign tbl.wr_en     = reg_wr && reg_addr[ADDR_W-1] && protected_write_enable;
	assign tbl.wr_index  = reg_addr[INDEX_W-1:0];
	assign tbl.wr_data   = reg_wdata;
	assign tbl.bus_index = reg_addr[INDEX_W-1:0];
	assign tbl.vec_index = fetch_index;

	// vector answer, one cycle after the request
	always_ff @(posedge clk) begin
		if (rst) begin
			vec_valid  <= 1'b0;
			vec_mapped <= 1'b0;
			vec_data   <= '0;
		end else begin
			vec_valid  <= vec_req;
			vec_mapped <= vec_req && expander_enable;
			if (vec_req && expander_enable) begin
				vec_data <= {tbl.vec_hi, tbl.vec_lo};
			end else begin
				vec_data <= '0;
			end
		end
	end

	// register read mux; unmapped addresses read zero
	always_comb begin
		next_rdata = '0;
		if (reg_addr[ADDR_W-1]) begin
			next_rdata = tbl.bus_data;
		end else if (reg_addr == ADDR_CTRL) begin
			next_rdata[CTRL_ENABLE_BIT] = expander_enable;
		end else if (reg_addr == ADDR_ACK) begin
			next_rdata = 16'(group_ack_latch);
		end else begin
			for (int g = 0; g < GROUPS; g++) begin
				if (reg_addr == 9'(ADDR_EN_BASE + 9'(g))) begin
					next_rdata = 16'(group_source_enables[g]);
				end
				if (reg_addr == 9'(ADDR_PEND_BASE + 9'(g))) begin
					next_rdata = 16'(group_pending_flags[g]);
				end
			end
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= '0;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	chk_pend_latch: assert property (
		(src_rise != '0) |=> ((pend_flat & $past(src_rise)) == $past(src_rise)))
		else $error("source request did not set its pending flag");

	chk_fire_cause: assert property (
		(cpu_line_req & ~$past(group_fire)) == '0)
		else $error("line request without enabled pending source and clear acknowledge");

	chk_ack_set: assert property (
		(group_fire != '0) |=> ((group_ack_latch & $past(group_fire)) == $past(group_fire)))
		else $error("acknowledge latch not set after a group request");

	chk_ack_blocks: assert property (
		(cpu_line_req & $past(cpu_line_req)) == '0)
		else $error("group requested twice without acknowledge clear");

	chk_vec_answer: assert property (
		vec_req |=> vec_valid ##1 !vec_valid || $past(vec_req))
		else $error("vector answer not one cycle after request");

	chk_prio_pick: assert property (
		fetch_clear |-> (fetch_hits & ((8'h01 << fetch_pos) - 8'h01)) == 8'h00 && fetch_hits[fetch_pos])
		else $error("vector decode did not pick highest priority source");

	chk_default_pos1: assert property (
		(vec_req && fetch_is_mux && (vec_sw || fetch_hits == 8'h00))
			|-> fetch_index == mux_index(fetch_grp, 3'h0))
		else $error("empty or trap fetch did not return position one");

	chk_clear_flag: assert property (
		fetch_clear && !src_rise[7'(fetch_grp) * 7'(SRC_PER_GROUP) + 7'(fetch_pos)]
			&& !(reg_wr && reg_addr == 9'(ADDR_PEND_BASE + 9'(fetch_grp)))
			|=> !pend_flat[$past(7'(fetch_grp) * 7'(SRC_PER_GROUP) + 7'(fetch_pos))])
		else $error("delivered source pending flag not cleared");

	chk_table_protect: assert property (
		(reg_wr && !protected_write_enable) |-> !tbl.wr_en)
		else $error("vector store written without protected write enable");

	chk_own_entry: assert property (
		(vec_req && !fetch_is_mux) |-> fetch_index == 8'(8'(vec_line) * ENTRY_WORDS))
		else $error("non multiplexed line used the wrong entry");

	chk_enable_reset: assert property (@(posedge clk) disable iff (1'b0)
		($past(rst) && !rst) |-> !expander_enable)
		else $error("expander enable not cleared by reset");

	// traps take position one and leave every pending flag alone
	chk_trap_pos1: assert property (
		(vec_req && vec_sw && fetch_is_mux) |-> (fetch_pos == 3'h0) && !fetch_clear)
		else $error("trap fetch decoded a source or cleared a flag");

	// with the expander off the answer is unmapped and zero
	chk_off_unmapped: assert property (
		(vec_req && !expander_enable) |=> vec_valid && !vec_mapped && (vec_data == '0))
		else $error("disabled expander returned a mapped vector");

	// a protected store write lands in the addressed word
	chk_store_write: assert property (
		(reg_wr && reg_addr[ADDR_W-1] && protected_write_enable)
			|=> (u_store.mem[$past(reg_addr[INDEX_W-1:0])] == $past(reg_wdata)))
		else $error("protected vector store write did not land");

	// every firing group reaches its own line in the same cycle
	chk_lines_together: assert property (
		(group_fire != '0) |=> (cpu_line_req == $past(group_fire)))
		else $error("group requests were not presented together");

	// software ones in the last group's pending word set those flags
	chk_soft_pend: assert property (
		(reg_wr && reg_addr == 9'(ADDR_PEND_BASE + 9'(GROUPS - 1)))
			|=> ((group_pending_flags[GROUPS-1] & $past(reg_wdata[SRC_PER_GROUP-1:0]))
				== $past(reg_wdata[SRC_PER_GROUP-1:0])))
		else $error("software write did not set pending flags");

	// read data stand only in the cycle after a read strobe
	chk_read_window: assert property (
		!$past(reg_rd) |-> (reg_rdata == '0))
		else $error("read data outside the cycle after a read strobe");

	// main scenarios the bench is expected to reach
	cov_group_fire: cover property (group_fire != '0 ##1 cpu_line_req != '0);
	cov_two_groups: cover property ($countones(group_fire) > 1);
	cov_hw_fetch: cover property (fetch_clear ##1 vec_valid && vec_mapped);
	cov_empty_fetch: cover property (vec_req && fetch_is_mux && !vec_sw && fetch_hits == 8'h00);
	cov_trap_fetch: cover property (vec_req && vec_sw && fetch_is_mux);
endmodule

/* File: design/expander_pkg.sv */
// constants shared by the interrupt expander and its vector store
package expander_pkg;
	localparam int              GROUPS          = 12;      // cpu lines fed through the expander
	localparam int              SRC_PER_GROUP   = 8;       // sources multiplexed onto one line
	localparam int              SOURCES         = 96;      // all multiplexed source positions
	localparam int              TABLE_DEPTH     = 256;     // vector store words
	localparam int              TABLE_WIDTH     = 16;      // vector store word width
	localparam int              ADDR_W          = 9;       // register port address width
	localparam int              DATA_W          = 16;      // register port data width
	localparam int              INDEX_W         = 8;       // vector store index width
	localparam int              LINE_W          = 5;       // cpu line number width
	localparam int              CTRL_ENABLE_BIT = 0;       // expander enable in control word
	localparam logic [8:0]      ADDR_CTRL       = 9'h000;
	localparam logic [8:0]      ADDR_ACK        = 9'h001;
	localparam logic [8:0]      ADDR_EN_BASE    = 9'h010;  // one word per group
	localparam logic [8:0]      ADDR_PEND_BASE  = 9'h020;  // one word per group
	localparam logic [8:0]      ADDR_TABLE_BASE = 9'h100;  // 256 words of vector store
	localparam logic [7:0]      MUX_TABLE_BASE  = 8'h40;   // first multiplexed entry
	localparam logic [7:0]      GROUP_STRIDE    = 8'h10;   // words per group
	localparam logic [7:0]      ENTRY_WORDS     = 8'h02;   // words per vector
	localparam logic [4:0]      FIRST_MUX_LINE  = 5'h01;
	localparam logic [4:0]      LAST_MUX_LINE   = 5'h0C;
	localparam logic            ENABLE_RESET    = 1'b0;    // expander off after reset
endpackage

/* File: design/table_if.sv */
// ports between the expander logic and its vector store
`timescale 1ns/1ps
interface table_if;
	logic        wr_en;
	logic [7:0]  wr_index;
	logic [15:0] wr_data;
	logic [7:0]  bus_index;
	logic [15:0] bus_data;
	logic [7:0]  vec_index;
	logic [15:0] vec_lo;
	logic [15:0] vec_hi;
	modport owner (output wr_en, wr_index, wr_data, bus_index, vec_index, input bus_data, vec_lo, vec_hi);
	modport store (input wr_en, wr_index, wr_data, bus_index, vec_index, output bus_data, vec_lo, vec_hi);
endinterface

/* File: design/vector_store.sv */
// 256 x 16 vector store, also plain data memory
`timescale 1ns/1ps
module vector_store
	import expander_pkg::*;
(
	input  wire logic clk,
	table_if.store    port
);
	logic [TABLE_WIDTH-1:0] mem [TABLE_DEPTH];

	// contents are left unreset on purpose; software loads them after boot
	always_ff @(posedge clk) begin
		if (port.wr_en) begin
			mem[port.wr_index] <= port.wr_data;
		end
	end

	// reads are combinational, the owner registers them
	assign port.bus_data = mem[port.bus_index];
	assign port.vec_lo   = mem[port.vec_index];
	assign port.vec_hi   = mem[8'(port.vec_index + 8'h01)];
endmodule

/* File: verification/cpu_model.sv */
// cpu side model: flags group lines and fetches their vectors
`timescale 1ns/1ps
module cpu_model
	import expander_pkg::*;
(
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic [GROUPS-1:0]        cpu_line_req,
	input  wire logic                     global_irq_mask,
	input  wire logic [GROUPS-1:0]        cpu_line_enables,
	input  wire logic                     vec_valid,
	input  wire logic [2*TABLE_WIDTH-1:0] vec_data,
	output logic                          vec_req,
	output logic      [LINE_W-1:0]        vec_line,
	output logic      [2*TABLE_WIDTH-1:0] last_vec
);
	logic [GROUPS-1:0] cpu_line_flags;
	logic [GROUPS-1:0] ready;
	logic              busy;

	// lines that may be serviced now
	assign ready = cpu_line_flags & cpu_line_enables;

	// flag group lines, then service the lowest numbered ready line
	always_ff @(posedge clk) begin
		if (rst) begin
			cpu_line_flags <= '0;
			vec_req        <= 1'b0;
			vec_line       <= '0;
			busy           <= 1'b0;
			last_vec       <= '0;
		end else begin
			vec_req        <= 1'b0;
			cpu_line_flags <= cpu_line_flags | cpu_line_req;
			if (busy && vec_valid) begin
				last_vec <= vec_data;
				busy     <= 1'b0;
			end
			if (!busy && !global_irq_mask && ready != '0) begin
				for (int k = GROUPS - 1; k >= 0; k--) begin
					if (ready[k]) begin
						vec_line <= LINE_W'(k + 1);
					end
				end
				cpu_line_flags <= (cpu_line_flags | cpu_line_req) & ~(ready & (~ready + 1'b1));
				vec_req        <= 1'b1;
				busy           <= 1'b1;
			end
		end
	end
endmodule

/* File: verification/grouped_interrupt_expander_test.sv */
// self-checking bench for the grouped interrupt expander
`timescale 1ns/1ps
module grouped_interrupt_expander_test
	import expander_pkg::*;
;
	logic               clk;
	logic               rst;
	logic [SOURCES-1:0] src_req;
	logic               protected_write_enable;
	logic [ADDR_W-1:0]  reg_addr;
	logic [DATA_W-1:0]  reg_wdata;
	logic               reg_wr;
	logic               reg_rd;
	logic [DATA_W-1:0]  reg_rdata;
	logic [GROUPS-1:0]  line_req;
	logic               t_req;
	logic [LINE_W-1:0]  t_line;
	logic               m_req;
	logic [LINE_W-1:0]  m_line;
	logic               vreq;
	logic [LINE_W-1:0]  vline;
	logic               vec_sw;
	logic               vec_valid;
	logic               vec_mapped;
	logic [31:0]        vec_data;
	logic               global_irq_mask;
	logic [GROUPS-1:0]  cpu_line_enables;
	logic [31:0]        last_vec;
	logic               both = 1'b0;
	int                 pcnt [GROUPS];
	int                 mismatches;
	int                 checked;

	// bench fetches and cpu model fetches share the vector port
	assign vreq  = t_req | m_req;
	assign vline = m_req ? m_line : t_line;

	grouped_interrupt_expander uut (
		.clk                    (clk),
		.rst                    (rst),
		.src_req                (src_req),
		.protected_write_enable (protected_write_enable),
		.reg_addr               (reg_addr),
		.reg_wdata              (reg_wdata),
		.reg_wr                 (reg_wr),
		.reg_rd                 (reg_rd),
		.reg_rdata              (reg_rdata),
		.cpu_line_req           (line_req),
		.vec_req                (vreq),
		.vec_line               (vline),
		.vec_sw                 (vec_sw),
		.vec_valid              (vec_valid),
		.vec_mapped             (vec_mapped),
		.vec_data               (vec_data)
	);

	cpu_model cpu (
		.clk              (clk),
		.rst              (rst),
		.cpu_line_req     (line_req),
		.global_irq_mask  (global_irq_mask),
		.cpu_line_enables (cpu_line_enables),
		.vec_valid        (vec_valid),
		.vec_data         (vec_data),
		.vec_req          (m_req),
		.vec_line         (m_line),
		.last_vec         (last_vec)
	);

	// table word written at each index
	function automatic logic [15:0] fv(input logic [7:0] i);
		return {8'hA5, i};
	endfunction

	// two-word vector starting at an even index
	function automatic logic [31:0] vec(input logic [7:0] i);
		return {fv(i + 8'h01), fv(i)};
	endfunction

	// table index of the position-one or own vector of a line
	function automatic logic [7:0] sw_idx(input int l);
		if (l >= 1 && l <= GROUPS) begin
			return MUX_TABLE_BASE + 8'((l - 1) * 16);
		end
		return 8'(l * 2);
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			mismatches++;
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		chk({16'h0000, reg_rdata}, {16'h0000, exp});
	endtask

	task automatic fetch(input logic [LINE_W-1:0] l, input logic s, input logic m, input logic [31:0] exp);
		@(posedge clk);
		t_req  <= 1'b1;
		t_line <= l;
		vec_sw <= s;
		@(posedge clk);
		t_req  <= 1'b0;
		vec_sw <= 1'b0;
		#1;
		chk({30'h0, vec_valid, vec_mapped}, {30'h0, 1'b1, m});
		chk(vec_data, exp);
	endtask

	// raise source lines long enough to pass the input synchroniser
	task automatic pulse(input logic [SOURCES-1:0] m);
		@(posedge clk);
		src_req <= m;
		repeat (6) @(posedge clk);
		src_req <= '0;
		repeat (2) @(posedge clk);
	endtask

	task automatic end_sim;
		if (mismatches == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// count line pulses and note lines one and eight together
	always @(posedge clk) begin
		for (int k = 0; k < GROUPS; k++) begin
			if (line_req[k] === 1'b1) begin
				pcnt[k]++;
			end
		end
		if (line_req[0] === 1'b1 && line_req[7] === 1'b1) begin
			both <= 1'b1;
		end
	end

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// main sequence
	initial begin
		rst = 1'b1;
		src_req = '0;
		protected_write_enable = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		t_req = 1'b0;
		t_line = '0;
		vec_sw = 1'b0;
		global_irq_mask = 1'b1;
		cpu_line_enables = '0;
		mismatches = 0;
		checked = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(ADDR_CTRL, 16'h0000);
		fetch(5'h01, 1'b0, 1'b0, 32'h0);
		wr(ADDR_TABLE_BASE + 9'h005, 16'h1234);
		protected_write_enable <= 1'b1;
		for (int i = 0; i < TABLE_DEPTH; i++) begin
			wr(ADDR_TABLE_BASE + 9'(i), fv(8'(i)));
		end
		protected_write_enable <= 1'b0;
		wr(ADDR_TABLE_BASE + 9'h005, 16'hFFFF);
		rd(ADDR_TABLE_BASE + 9'h005, fv(8'h05));
		rd(9'h0FF, 16'h0000);
		wr(ADDR_CTRL, 16'h0001);
		rd(ADDR_CTRL, 16'h0001);
		for (int l = 0; l < 32; l++) begin
			fetch(5'(l), 1'b1, 1'b1, vec(sw_idx(l)));
		end
		fetch(5'h03, 1'b0, 1'b1, vec(8'h60));
		wr(ADDR_EN_BASE, 16'h0081);
		pulse(96'h81);
		rd(ADDR_PEND_BASE, 16'h0081);
		rd(ADDR_ACK, 16'h0001);
		chk(32'(pcnt[0]), 32'h1);
		fetch(5'h01, 1'b0, 1'b1, vec(8'h40));
		rd(ADDR_PEND_BASE, 16'h0080);
		fetch(5'h01, 1'b0, 1'b1, vec(8'h4E));
		rd(ADDR_PEND_BASE, 16'h0000);
		pulse(96'h1);
		chk(32'(pcnt[0]), 32'h1);
		wr(ADDR_ACK, 16'h0001);
		rd(ADDR_ACK, 16'h0001);
		chk(32'(pcnt[0]), 32'h2);
		fetch(5'h01, 1'b0, 1'b1, vec(8'h40));
		pulse(96'h200);
		rd(ADDR_PEND_BASE + 9'h001, 16'h0002);
		chk(32'(pcnt[1]), 32'h0);
		wr(ADDR_EN_BASE + 9'h00B, 16'h0004);
		wr(ADDR_PEND_BASE + 9'h00B, 16'h0004);
		wr(ADDR_PEND_BASE + 9'h00B, 16'h0000);
		rd(ADDR_PEND_BASE + 9'h00B, 16'h0004);
		chk(32'(pcnt[11]), 32'h1);
		wr(ADDR_ACK, 16'h0081);
		wr(ADDR_EN_BASE + 9'h007, 16'h0001);
		global_irq_mask <= 1'b0;
		cpu_line_enables <= 12'h081;
		pulse((96'h1 << 56) | 96'h1);
		for (int n = 0; n < 60 && last_vec !== vec(8'hB0); n++) begin
			@(posedge clk);
		end
		chk(last_vec, vec(8'hB0));
		chk({31'h0, both}, 32'h1);
		rd(ADDR_PEND_BASE + 9'h007, 16'h0000);
		// discard one flag through an empty routine, then restore the table word
		global_irq_mask <= 1'b1;
		protected_write_enable <= 1'b1;
		wr(ADDR_TABLE_BASE + 9'h04E, 16'h0BAD);
		pulse(96'h80);
		wr(ADDR_ACK, 16'h0001);
		global_irq_mask <= 1'b0;
		for (int n = 0; n < 20 && last_vec !== {fv(8'h4F), 16'h0BAD}; n++) begin
			@(posedge clk);
		end
		chk(last_vec, {fv(8'h4F), 16'h0BAD});
		global_irq_mask <= 1'b1;
		wr(ADDR_TABLE_BASE + 9'h04E, fv(8'h4E));
		protected_write_enable <= 1'b0;
		wr(ADDR_EN_BASE, 16'h0001);
		wr(ADDR_ACK, 16'h0001);
		global_irq_mask <= 1'b0;
		rd(ADDR_TABLE_BASE + 9'h04E, fv(8'h4E));
		rd(ADDR_PEND_BASE, 16'h0000);
		rd(ADDR_ACK, 16'h0880);
		end_sim;
	end
endmodule
